// ===== hw/spi_ctrl.sv
/*
  spi master/slave controller with apb register access.
  assumes core_clk is the base clock, pins are resolved outside from the
  o/oe pairs, and every pin input is asynchronous to core_clk.
*/
// Contract
// - receive-full interrupt request only when its enable is set; reset clears enable
// - master select bit 1 gives master, 0 slave; reset selects master
// - polarity bit sets serial clock idle level; reset clears it
// - phase bit picks launch and sample edges; reset sets it
// - both parties use identical polarity and phase
// - wired-or bit makes clock and data pins open-drain, else push-pull
// - works only while enabled; clearing enable partly resets; reset clears it
// - transmit-empty interrupt request only while its enable is set; reset clears
// - receive-full flag sets when a byte moves to receive register
// - receive-full clears by status read with flag set, then data read
// - error enable lets mode-fault and overflow request interrupts; reset clears
// - byte completing while receive full sets overflow, keeps old byte
// - overflow clears by status read with flag set, then data read
// - slave with fault enable flags mode fault if select rises mid-transfer
// - master with fault enable flags mode fault whenever select falls
// - mode fault clears by status read with flag set, then control write
// - transmit-empty sets on hand-off to shifter, clears on data write, resets set
// - fault enable gates only setting of mode fault, never clears it
// - master without fault enable ignores and frees select; slave always uses it
// - master rate codes pick divisor 2, 8, 32, 128; clock is base over twice it
// - data address writes transmit register, reads receive register; no reset
// - one byte exchanged full duplex in eight serial clock cycles
// - deselected slave floats its data output and ignores clock edges
`timescale 1ns/1ns
`include "spi_defines.svh"
module spi_ctrl (
  input  wire logic        core_clk,     // base clock
  input  wire logic        rst,          // async reset, active high
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb access phase
  input  wire logic        pwrite,       // apb direction
  input  wire logic [9:0]  paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // unmapped address
  input  wire logic        sclk_i,       // serial clock pin level
  output logic             sclk_o,       // serial clock drive value
  output logic             sclk_oe,      // serial clock drive enable
  input  wire logic        mosi_i,       // master-out pin level
  output logic             mosi_o,       // master-out drive value
  output logic             mosi_oe,      // master-out drive enable
  input  wire logic        miso_i,       // master-in pin level
  output logic             miso_o,       // master-in drive value
  output logic             miso_oe,      // master-in drive enable
  input  wire logic        ss_n_i,       // slave select pin, low active
  output logic             ss_gpio_free, // select pin left to port logic
  output logic             irq           // cpu interrupt request
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [3:0]  meta_q, sync_q;
  logic [7:0]  ctrl_q, cfg_q;
  logic        rxf_q, ovr_q, mode_fault_flag_q, txe_q;
  logic        rxf_arm_q, ovr_arm_q, mode_fault_flag_arm_q;
  logic [7:0]  tx_q, rx_q, shift_q;
  logic [7:0]  shift_d;
  logic        tail_q, sclk_q, sclk_prev_q, ss_prev_q;
  logic [2:0]  bits_q;
  logic [6:0]  div_q;
  logic [3:0]  cnt_q;
  spi_pkg::xfer_state_type st_q;
  logic        pready_q, pslverr_q, irq_q, gpio_q;
  logic [31:0] prdata_q;
  logic        sclk_o_q, sclk_oe_q, mosi_o_q, mosi_oe_q, miso_o_q, miso_oe_q;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // two flops per pin; only sync_q is read by logic
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      meta_q <= 4'hf;
      sync_q <= 4'hf;
    end
    else
    begin
      meta_q <= {ss_n_i, miso_i, mosi_i, sclk_i};
      sync_q <= meta_q;
    end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  wire sclk_s  = sync_q[0];
  wire mosi_s  = sync_q[1];
  wire miso_s  = sync_q[2];
  wire ss_n_s  = sync_q[3];
  wire en      = ctrl_q[`C_EN];
  wire mstr    = ctrl_q[`C_MSTR];
  wire clock_polarity    = ctrl_q[`C_CLOCK_POLARITY];
  wire clock_phase    = ctrl_q[`C_CLOCK_PHASE];
  wire wom     = ctrl_q[`C_WOM];
  wire rxie    = ctrl_q[`C_RXIE];
  wire txie    = ctrl_q[`C_TXIE];
  wire error_irq_enable   = cfg_q[`S_ERROR_IRQ_ENABLE];
  wire mode_fault_enable  = cfg_q[`S_MODE_FAULT_ENABLE];
  wire [1:0] rate = {cfg_q[`S_RATE_HI], cfg_q[`S_RATE_LO]};
  wire master  = en & mstr;
  wire slave   = en & ~mstr;
  wire sel     = ~ss_n_s;
  wire idle    = st_q == spi_pkg::XFER_IDLE;
  wire run     = st_q == spi_pkg::XFER_RUN;

  // ----------------------------------------
  // apb decode, one wait state on every access
  // ----------------------------------------
  wire setup    = psel & ~penable;
  wire access   = psel & penable & pready_q;
  wire hit_ctrl = paddr == {`IDX_CTRL, `ADDR_PAD};
  wire hit_stat = paddr == {`IDX_STAT, `ADDR_PAD};
  wire hit_data = paddr == {`IDX_DATA, `ADDR_PAD};
  wire mapped   = hit_ctrl | hit_stat | hit_data;
  wire wr_ctrl  = access & pwrite & hit_ctrl;
  wire wr_stat  = access & pwrite & hit_stat;
  wire wr_data  = access & pwrite & hit_data;
  wire rd_stat  = access & ~pwrite & hit_stat;
  wire rd_data  = access & ~pwrite & hit_data;
  wire [7:0] stat_val = {rxf_q, error_irq_enable, ovr_q, mode_fault_flag_q, txe_q, mode_fault_enable, rate};
  wire [7:0] rd_val = hit_ctrl ? ctrl_q : hit_stat ? stat_val : hit_data ? rx_q : 8'h00;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      if (setup)
        prdata_q <= {24'h00_0000, rd_val};
    end

  // ----------------------------------------
  // serial edge events
  // ----------------------------------------
  // a master edge is the end of a half period count; none in the tail
  wire m_edge  = run & master & ~tail_q & (div_q == 7'h00);
  wire m_last  = m_edge & (cnt_q == `LAST_EDGE);
  // both modes sample on edges of the synchronised clock pin, so a master
  // hears its own clock with the same lag as the data coming back
  wire pin_edge = sclk_s ^ sclk_prev_q;
  // deselected slave sees no edges at all
  wire samp_ev = run & (master | sel) & pin_edge & (sclk_s ^ clock_polarity ^ clock_phase);
  wire done    = samp_ev & (bits_q == `LAST_BIT);
  wire din     = mstr ? miso_s : mosi_s;
  wire [7:0] byte_in = {shift_q[6:0], din};
  wire ss_fall = ss_prev_q & ~ss_n_s;
  wire ss_rise = ~ss_prev_q & ss_n_s;
  // a master fault is any fall of select while fault enable is set; aborts the transfer
  wire m_fault = master & mode_fault_enable & ss_fall;
  wire s_fault = slave & mode_fault_enable & run & ss_rise;
  wire m_start = master & idle & ~txe_q;
  // with phase 0 a byte begins on the select fall
  wire s_start = slave & idle & sel & (clock_phase | ss_fall);
  wire load    = (m_start & ~m_fault) | s_start;
  wire abort   = ~en | (slave & ss_n_s) | m_fault;
  wire accept  = done & (~rxf_q | (rd_data & rxf_arm_q));
  wire ovr_set = done & ~accept;

  // next shifter content, msb leaves first; in and out move together
  assign shift_d = (load & ~txe_q) ? tx_q :
                   samp_ev ? byte_in : shift_q;

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      st_q        <= spi_pkg::XFER_IDLE;
      cnt_q       <= `FIRST_EDGE;
      div_q       <= `HALF_R0;
      sclk_q      <= 1'b0;
      sclk_prev_q <= 1'b0;
      ss_prev_q   <= 1'b1;
      tail_q      <= 1'b0;
      bits_q      <= 3'h0;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      ss_prev_q   <= ss_n_s;
      if (abort | (idle & ~load) | done)
      begin
        st_q   <= spi_pkg::XFER_IDLE;
        cnt_q  <= `FIRST_EDGE;
        tail_q <= 1'b0;
        bits_q <= 3'h0;
        div_q  <= spi_pkg::half_reload(rate);
        sclk_q <= clock_polarity;
      end
      else if (load)
      begin
        st_q  <= spi_pkg::XFER_RUN;
        div_q <= spi_pkg::half_reload(rate);
      end
      else
      begin
        if (m_edge)
          cnt_q <= cnt_q + 4'h1;
        // after the last master edge wait for its echo to be sampled
        if (m_last)
          tail_q <= 1'b1;
        if (samp_ev)
          bits_q <= bits_q + 3'h1;
        if (m_edge)
        begin
          sclk_q <= ~sclk_q;
          div_q  <= spi_pkg::half_reload(rate);
        end
        else if (master)
          div_q <= div_q - 7'h01;
      end
    end

  // data registers keep their content through reset
  always_ff @(posedge core_clk)
  begin
    shift_q <= shift_d;
    if (wr_data)
      tx_q <= pwdata[7:0];
    if (accept)
      rx_q <= byte_in;
  end

  // ----------------------------------------
  // control and configuration registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      ctrl_q <= `CTRL_RESET;
      cfg_q  <= `CFG_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata[7:0];
      if (wr_stat)
        cfg_q <= pwdata[7:0] & `CFG_MASK;
    end

  // ----------------------------------------
  // status flags, a set always beats a clear
  // ----------------------------------------
  // a status read with the flag up arms the clearing access
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      rxf_q      <= 1'b0;
      ovr_q      <= 1'b0;
      mode_fault_flag_q     <= 1'b0;
      txe_q      <= 1'b1;
      rxf_arm_q  <= 1'b0;
      ovr_arm_q  <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end
    else
    begin
      if (rd_stat & rxf_q)
        rxf_arm_q <= 1'b1;
      else if (rd_data)
        rxf_arm_q <= 1'b0;
      if (rd_stat & ovr_q)
        ovr_arm_q <= 1'b1;
      else if (rd_data)
        ovr_arm_q <= 1'b0;
      if (rd_stat & mode_fault_flag_q)
        mode_fault_flag_arm_q <= 1'b1;
      else if (wr_ctrl)
        mode_fault_flag_arm_q <= 1'b0;
      if (accept)
        rxf_q <= 1'b1;
      else if (rd_data & rxf_arm_q)
        rxf_q <= 1'b0;
      if (ovr_set)
        ovr_q <= 1'b1;
      else if (rd_data & ovr_arm_q)
        ovr_q <= 1'b0;
      // fault enable only gates the set side
      if (m_fault | s_fault)
        mode_fault_flag_q <= 1'b1;
      else if (wr_ctrl & mode_fault_flag_arm_q)
        mode_fault_flag_q <= 1'b0;
      if (load & ~txe_q)
        txe_q <= 1'b1;
      else if (wr_data)
        txe_q <= 1'b0;
    end

  // ----------------------------------------
  // pin drivers and interrupt, all registered
  // ----------------------------------------
  // open-drain drives only a low, the pull-up makes the high
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      sclk_o_q  <= 1'b0;
      sclk_oe_q <= 1'b0;
      mosi_o_q  <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_o_q  <= 1'b0;
      miso_oe_q <= 1'b0;
      irq_q     <= 1'b0;
      gpio_q    <= 1'b1;
    end
    else
    begin
      sclk_o_q  <= sclk_q & ~wom;
      sclk_oe_q <= master & (~wom | ~sclk_q);
      mosi_o_q  <= shift_d[7] & ~wom;
      mosi_oe_q <= master & (~wom | ~shift_d[7]);
      miso_o_q  <= shift_d[7] & ~wom;
      miso_oe_q <= slave & sel & (~wom | ~shift_d[7]);
      irq_q     <= (rxie & rxf_q) | (txie & txe_q)
                 | (error_irq_enable & (ovr_q | mode_fault_flag_q));
      gpio_q    <= ~en | (mstr & ~mode_fault_enable);
    end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign sclk_o       = sclk_o_q;
  assign sclk_oe      = sclk_oe_q;
  assign mosi_o       = mosi_o_q;
  assign mosi_oe      = mosi_oe_q;
  assign miso_o       = miso_o_q;
  assign miso_oe      = miso_oe_q;
  assign irq          = irq_q;
  assign ss_gpio_free = gpio_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  rx_full_set_a: assert property (accept |=> rxf_q && rx_q == $past(byte_in))
    else $error("receive full not set on byte completion");
  overflow_keep_a: assert property (ovr_set |=> ovr_q && $stable(rx_q))
    else $error("overflow lost or old byte overwritten");
  tx_empty_clr_a: assert property (wr_data && !load |=> !txe_q)
    else $error("transmit empty not cleared by data write");
  slave_float_a: assert property (slave && ss_n_s |=> !miso_oe)
    else $error("deselected slave drives master-in");
  idle_level_a: assert property (idle && !load && en ##1 idle |-> sclk_q == $past(clock_polarity))
    else $error("serial clock idle level wrong");
  fast_rate_a: assert property (m_edge && rate == 2'h0 && !m_last |=> !m_edge ##1 (m_edge || !run))
    else $error("divisor two half period wrong");
  disable_idle_a: assert property (!en |=> idle && cnt_q == `FIRST_EDGE)
    else $error("disabled block still transferring");
  fault_hold_a: assert property (mode_fault_flag_q && !(wr_ctrl && mode_fault_flag_arm_q) |=> mode_fault_flag_q)
    else $error("mode fault dropped without clearing sequence");
  master_fault_a: assert property (master && mode_fault_enable && ss_fall |=> mode_fault_flag_q && idle)
    else $error("master select fall not flagged");
  irq_gate_a: assert property (!rxie && !txie && !error_irq_enable |=> !irq)
    else $error("interrupt raised while all enables off");
  tx_load_a: assert property (load && !txe_q |=> txe_q && shift_q == $past(tx_q))
    else $error("transmit byte not handed to shifter");
  byte_done_a: assert property (done |=> idle)
    else $error("transfer not ended after eighth bit");
endmodule : spi_ctrl

// ===== hw/spi_defines.svh
/*
  register indices, field positions, reset values and counts of the spi
  controller. assumes it is included by bare name, definitions only.
*/
`ifndef SPI_DEFINES_SVH
`define SPI_DEFINES_SVH
// ----------------------------------------
// register indices, byte address is index times four
// ----------------------------------------
`define IDX_CTRL    8'h4c
`define IDX_STAT    8'h4d
`define IDX_DATA    8'h4e
`define ADDR_PAD    2'h0
// ----------------------------------------
// control register fields
// ----------------------------------------
`define C_RXIE      7
`define C_MSTR      5
`define C_CLOCK_POLARITY      4
`define C_CLOCK_PHASE      3
`define C_WOM       2
`define C_EN        1
`define C_TXIE      0
`define CTRL_RESET  8'h28
// ----------------------------------------
// status and control register fields
// ----------------------------------------
`define S_RXF       7
`define S_ERROR_IRQ_ENABLE     6
`define S_OVR       5
`define S_MODE_FAULT_FLAG      4
`define S_TXE       3
`define S_MODE_FAULT_ENABLE    2
`define S_RATE_HI   1
`define S_RATE_LO   0
`define CFG_MASK    8'h47
`define CFG_RESET   8'h00
// ----------------------------------------
// serial timing: half period reload is divisor minus one
// ----------------------------------------
`define HALF_R0     7'h01
`define HALF_R1     7'h07
`define HALF_R2     7'h1f
`define HALF_R3     7'h7f
`define FIRST_EDGE  4'h0
`define LAST_EDGE   4'hf
`define LAST_BIT    3'h7
`endif

// ===== hw/spi_pkg.sv
/*
  types and shared decode of the spi controller.
  assumes spi_defines.svh is on the include path.
*/
`include "spi_defines.svh"
package spi_pkg;
  typedef enum logic {XFER_IDLE, XFER_RUN} xfer_state_type;
  // half period reload for a rate code
  function automatic logic [6:0] half_reload(input logic [1:0] code);
    logic [6:0] r;
    r = `HALF_R0;
    unique case (code)
      2'h0: r = `HALF_R0;
      2'h1: r = `HALF_R1;
      2'h2: r = `HALF_R2;
      2'h3: r = `HALF_R3;
    endcase
    return r;
  endfunction : half_reload
endpackage : spi_pkg

// ===== tb/spi_slave_model.sv
/*
  behavioural serial slave on the far side of the controller's link.
  assumes the bench resolves the pins and drives select, polarity and phase.
*/
`timescale 1ns/1ns
module spi_slave_model (
  input  wire logic       sclk,    // resolved serial clock
  input  wire logic       mosi,    // resolved master-out
  input  wire logic       ss_n,    // select, low active
  input  wire logic       clock_polarity,    // idle clock level used here
  input  wire logic       clock_phase,    // phase used here
  input  wire logic [7:0] tx_byte, // byte to answer with
  output logic            miso,    // master-in drive value
  output logic            miso_oe, // master-in drive enable
  output logic      [7:0] rx_byte  // last whole byte seen
);
  logic [7:0] txs;
  logic [7:0] rxs;
  int         bits;
  // ----------------------------------------
  // shifting
  // ----------------------------------------
  // a fresh byte is fetched at the first launch of each byte
  task automatic launch();
    if (bits == 0)
      txs = tx_byte;
    miso = txs[7];
    txs = {txs[6:0], 1'b0};
  endtask : launch
  // start state
  initial
  begin
    miso = 1'b1;
    bits = 0;
    rx_byte = 8'h00;
    rxs = 8'h00;
  end
  // deselected: pin floats and goes to its pull-up
  assign miso_oe = ~ss_n;
  // phase 0 must present its first bit before any clock edge
  always @(negedge ss_n)
  begin
    bits = 0;
    if (!clock_phase)
      launch();
  end
  // sample on leading edge for phase 0, trailing for phase 1
  always @(sclk)
  begin
    if (!ss_n && ((sclk != clock_polarity) ^ clock_phase))
    begin
      rxs = {rxs[6:0], mosi};
      bits++;
      if (bits == 8)
      begin
        rx_byte = rxs;
        bits = 0;
      end
    end
    else if (!ss_n)
      launch();
  end
endmodule : spi_slave_model

// ===== tb/spi_ctrl_tb.sv
/*
  self-checking bench of the spi controller: apb tasks, a slave model.
  assumes the controller has a one wait state apb and pulled-up pins.
*/
`timescale 1ns/1ns
`include "spi_defines.svh"
module spi_ctrl_tb;
  localparam logic [9:0] a_ctrl = {`IDX_CTRL, `ADDR_PAD};
  localparam logic [9:0] a_stat = {`IDX_STAT, `ADDR_PAD};
  localparam logic [9:0] a_data = {`IDX_DATA, `ADDR_PAD};
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n, ss_gpio_free;
  logic        m_miso, m_oe, clock_phase;
  logic [7:0]  m_tx, m_rx, rd;
  int          miscompares, tests_run;
  int          bd[4] = '{2, 8, 32, 128};
  // ----------------------------------------
  // pins: every line has a pull-up
  // ----------------------------------------
  wire sclk_pin = sclk_oe ? sclk_o : 1'b1;
  wire mosi_pin = mosi_oe ? mosi_o : 1'b1;
  wire miso_pin = miso_oe ? miso_o : (m_oe ? m_miso : 1'b1);
  spi_ctrl dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_i(sclk_pin), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_pin), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_pin), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n),
    .ss_gpio_free(ss_gpio_free), .irq(irq));
  spi_slave_model far_u (.sclk(sclk_pin), .mosi(mosi_pin), .ss_n(ss_n), .clock_polarity(1'b0), .clock_phase(clock_phase),
    .tx_byte(m_tx), .miso(m_miso), .miso_oe(m_oe), .rx_byte(m_rx));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stuck(input string what);
    miscompares++;
    $display("[ERR] %s expected done seen timeout", what);
    results();
  endtask : stuck
  // request held until pready is sampled high, released after that edge
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] v, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (n > 40)
        stuck("pready");
    end
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    logic e;
    apb(1'b1, a, v, e);
  endtask : wr
  task automatic rdc(input string what, input logic [9:0] a, input logic [7:0] exp);
    logic e;
    apb(1'b0, a, 8'h00, e);
    chk(what, exp, rd);
    chk("slave error", 8'h00, {7'h0, e});
  endtask : rdc
  task automatic poll_stat(input logic [7:0] mask);
    int n;
    logic e;
    n = 0;
    do
    begin
      apb(1'b0, a_stat, 8'h00, e);
      n++;
      if (n > 400)
        stuck("status flag");
    end
    while ((rd & mask) === 8'h00);
  endtask : poll_stat
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1)
    begin
      @(posedge core_clk);
      n++;
      if (n > 3000)
        stuck("irq");
    end
  endtask : wait_irq
  // counts core cycles between two serial clock edges at the pin
  task automatic half_period(input int exp);
    logic p;
    int n;
    for (int k = 0; k < 2; k++)
    begin
      p = sclk_pin;
      n = 0;
      while (sclk_pin === p)
      begin
        @(posedge core_clk);
        n++;
        if (n > 600)
          stuck("sclk edge");
      end
    end
    chk("half period", exp[7:0], n[7:0]);
  endtask : half_period
  // ----------------------------------------
  // clock and sequence
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // main sequence; settle waits let registered outputs land
  initial
  begin
    logic e;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    ss_n = 1'b1;
    clock_phase = 1'b1;
    m_tx = 8'h00;
    miscompares = 0;
    tests_run = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("irq", 8'h00, {7'h0, irq});
    chk("select free", 8'h01, {7'h0, ss_gpio_free});
    rdc("control", a_ctrl, 8'h28);
    rdc("status", a_stat, 8'h08);
    apb(1'b0, 10'h000, 8'h00, e);
    chk("unmapped data", 8'h00, rd);
    chk("unmapped error", 8'h01, {7'h0, e});
    wr(a_ctrl, 8'h2a);
    repeat (4) @(posedge core_clk);
    chk("sclk idle", 8'h00, {7'h0, sclk_pin});
    chk("select free", 8'h01, {7'h0, ss_gpio_free});
    chk("irq", 8'h00, {7'h0, irq});
    wr(a_ctrl, 8'h2b);
    repeat (4) @(posedge core_clk);
    chk("irq", 8'h01, {7'h0, irq});
    wr(a_ctrl, 8'h3e);
    repeat (4) @(posedge core_clk);
    chk("sclk oe", 8'h00, {7'h0, sclk_oe});
    chk("sclk idle", 8'h01, {7'h0, sclk_pin});
    wr(a_ctrl, 8'h2e);
    repeat (4) @(posedge core_clk);
    chk("sclk drive", 8'h01, {sclk_o, 6'h0, sclk_oe});
    // every rate code, full duplex bytes with the far side
    wr(a_ctrl, 8'haa);
    ss_n <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      wr(a_stat, c[7:0]);
      m_tx <= 8'h3c ^ c[7:0];
      wr(a_data, 8'h5a + c[7:0]);
      half_period(bd[c]);
      wait_irq();
      rdc("status", a_stat, 8'h88 | c[7:0]);
      rdc("rx data", a_data, 8'h3c ^ c[7:0]);
      chk("far byte", 8'h5a + c[7:0], m_rx);
      rdc("status", a_stat, 8'h08 | c[7:0]);
    end
    // second byte lands on an unread one
    wr(a_stat, 8'h00);
    m_tx <= 8'h11;
    wr(a_data, 8'h01);
    wait_irq();
    m_tx <= 8'h22;
    wr(a_data, 8'h02);
    poll_stat(8'h20);
    wr(a_ctrl, 8'h2a);
    repeat (4) @(posedge core_clk);
    chk("irq", 8'h00, {7'h0, irq});
    wr(a_stat, 8'h40);
    repeat (4) @(posedge core_clk);
    chk("irq", 8'h01, {7'h0, irq});
    rdc("status", a_stat, 8'he8);
    rdc("rx data", a_data, 8'h11);
    rdc("status", a_stat, 8'h48);
    // select falls under a master with fault detection on
    ss_n <= 1'b1;
    wr(a_stat, 8'h44);
    repeat (4) @(posedge core_clk);
    chk("select free", 8'h00, {7'h0, ss_gpio_free});
    ss_n <= 1'b0;
    poll_stat(8'h10);
    chk("irq", 8'h01, {7'h0, irq});
    wr(a_stat, 8'h40);
    rdc("status", a_stat, 8'h58);
    wr(a_ctrl, 8'h2a);
    rdc("status", a_stat, 8'h48);
    // phase 0: select raised between bytes
    wr(a_ctrl, 8'ha2);
    clock_phase <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      ss_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      m_tx <= 8'h96 ^ k[7:0];
      @(posedge core_clk);
      ss_n <= 1'b0;
      wr(a_data, 8'hc3 ^ k[7:0]);
      wait_irq();
      rdc("status", a_stat, 8'hc8);
      rdc("rx data", a_data, 8'h96 ^ k[7:0]);
      chk("far byte", 8'hc3 ^ k[7:0], m_rx);
    end
    wr(a_ctrl, 8'h20);
    repeat (4) @(posedge core_clk);
    chk("released", 8'h01, {sclk_oe, mosi_oe, 5'h0, ss_gpio_free});
    results();
  end
endmodule : spi_ctrl_tb
